// ===== core/rfhsp_consts.vh
/*
  constants of the radio module host serial port: register offsets,
  field positions, reset values and timing counts.
  assumes a 100 mhz core clock.
*/
`ifndef RFHSP_CONSTS_VH
`define RFHSP_CONSTS_VH

// register offsets on the plain register port
`define RFHSP_OFF_CTRL       4'h0
`define RFHSP_OFF_STATUS     4'h1
`define RFHSP_OFF_EXC        4'h2
`define RFHSP_OFF_EXC_MASK   4'h3
`define RFHSP_OFF_IRQ_STAT   4'h4
`define RFHSP_OFF_IRQ_CLR    4'h5
`define RFHSP_OFF_IRQ_EN     4'h6
`define RFHSP_OFF_CMD_DATA   4'h7
`define RFHSP_OFF_PAY_DATA   4'h8
`define RFHSP_OFF_RF_STATE   4'h9
`define RFHSP_OFF_BAUD       4'ha

// ctrl fields
`define RFHSP_CTRL_ACK_EN    0
`define RFHSP_CTRL_RESET     8'h00
// rf state field: 0 idle, 1 receive, 2 transmit
`define RFHSP_RF_IDLE        2'h0
`define RFHSP_RF_RX          2'h1
`define RFHSP_RF_TX          2'h2
// status fields
`define RFHSP_ST_RX_VALID    0
`define RFHSP_ST_TX_BUSY     1
`define RFHSP_ST_DRAINED     2
`define RFHSP_ST_DEFAULTS    3
`define RFHSP_ST_CLASS       4
// interrupt status bits
`define RFHSP_IRQ_RX_BYTE    0
`define RFHSP_IRQ_EXC        1
`define RFHSP_IRQ_DEFAULTS   2
`define RFHSP_IRQ_FRAME_ERR  3

`define RFHSP_EXC_MASK_RESET 8'hff
// baud divider: 100 mhz / 115200 baud
`define RFHSP_CLK_HZ         100000000
`define RFHSP_BAUD_DEFAULT   115200
`define RFHSP_BAUD_DIV       (`RFHSP_CLK_HZ / `RFHSP_BAUD_DEFAULT)
// factory-default sequence: extended high of 1 s, pulses no more than 1 s apart
`define RFHSP_LONG_HIGH_MS   1000
`define RFHSP_LONG_HIGH_CYC  (`RFHSP_LONG_HIGH_MS * (`RFHSP_CLK_HZ / 1000))
`define RFHSP_PULSE_GAP_MS   1000
`define RFHSP_PULSE_GAP_CYC  (`RFHSP_PULSE_GAP_MS * (`RFHSP_CLK_HZ / 1000))
`define RFHSP_PULSE_COUNT    3'h4
// indicator flash lengths
`define RFHSP_FLASH_MS_IDLE  50
`define RFHSP_FLASH_MS_ACT   200
`define RFHSP_FLASH_PERIOD_MS 1000

`endif

// ===== core/rfhsp_uart_rx.v
/*
  8n1 serial receiver with mid-bit sampling.
  assumes i_rx already synchronised to i_core_clk.
*/
`include "rfhsp_consts.vh"
module rfhsp_uart_rx #(
  parameter DIV_W = 16
) (
  input  wire             i_core_clk,
  input  wire             i_nrst,
  input  wire             i_ce,
  input  wire [DIV_W-1:0] i_div,
  input  wire             i_rx,
  output reg  [7:0]       o_data,
  output reg              o_valid,
  output reg              o_frame_err
);
  localparam S_IDLE  = 2'h0;
  localparam S_START = 2'h1;
  localparam S_DATA  = 2'h2;
  localparam S_STOP  = 2'h3;

  reg [1:0]       state_ff;
  reg [DIV_W-1:0] cnt_ff;
  reg [2:0]       bit_ff;
  reg [7:0]       sh_ff;

  always @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      state_ff    <= S_IDLE;
      cnt_ff      <= {DIV_W{1'b0}};
      bit_ff      <= 3'h0;
      sh_ff       <= 8'h00;
      o_data      <= 8'h00;
      o_valid     <= 1'b0;
      o_frame_err <= 1'b0;
    end else if (i_ce) begin
      o_valid     <= 1'b0;
      o_frame_err <= 1'b0;
      case (state_ff)
        S_IDLE: begin
          if (!i_rx) begin
            state_ff <= S_START;
            cnt_ff   <= {1'b0, i_div[DIV_W-1:1]};
          end
        end
        S_START: begin
          if (cnt_ff != {DIV_W{1'b0}}) begin
            cnt_ff <= cnt_ff - 1'b1;
          end else if (i_rx) begin
            state_ff <= S_IDLE; // glitch, not a start bit
          end else begin
            state_ff <= S_DATA;
            cnt_ff   <= i_div;
            bit_ff   <= 3'h0;
          end
        end
        S_DATA: begin
          if (cnt_ff != {DIV_W{1'b0}}) begin
            cnt_ff <= cnt_ff - 1'b1;
          end else begin
            sh_ff  <= {i_rx, sh_ff[7:1]};
            cnt_ff <= i_div;
            bit_ff <= bit_ff + 1'b1;
            if (bit_ff == 3'h7) begin
              state_ff <= S_STOP;
            end
          end
        end
        S_STOP: begin
          if (cnt_ff != {DIV_W{1'b0}}) begin
            cnt_ff <= cnt_ff - 1'b1;
          end else begin
            state_ff    <= S_IDLE;
            o_data      <= sh_ff;
            o_valid     <= i_rx;
            o_frame_err <= !i_rx;
          end
        end
        default: begin
          state_ff <= S_IDLE;
        end
      endcase
    end
  end
endmodule // rfhsp_uart_rx

// ===== core/rfhsp_top.v
/*
  host-facing serial port of a frequency-hopping radio module: serial in
  and out, byte-class select, flow control, drained, response marker,
  exception flag, amplifier enables, activity flash, factory-default pin.
  assumes a core register port on i_core_clk; the radio engine side is
  reached through the payload/command registers and the rf state field.
*/
// Design decisions made here: the strobed register port and the address map.
// Functional notes
// - the port is held in reset while the reset pin is low; high runs it.
// - a byte taken while the class select is low is a command, high is payload.
// - while the power-down pin is low the port is frozen and inert.
// - clear-to-send is high while busy and low when another byte may come.
// - four high pulses then a long high on the default pin restore defaults.
// - the receive amplifier enable is high while receiving.
// - the transmit amplifier enable is high while transmitting.
// - an exception whose mask bit is set raises the exception flag.
// - reading the exception register lowers the exception flag.
// - payload and command responses leave on one serial output.
// - the response marker is low while a command response is being sent.
// - the drained output is high when the input byte is taken and sent.
// - with ack enabled, drained after a payload byte also waits for ack or retry exception.
// - the activity indicator flashes with a length that shows the state.
`include "rfhsp_consts.vh"
module rfhsp_top #(
  parameter DIV_W        = 16,
  parameter LONG_HIGH    = `RFHSP_LONG_HIGH_CYC,
  parameter PULSE_GAP    = `RFHSP_PULSE_GAP_CYC,
  parameter FLASH_PERIOD = `RFHSP_FLASH_PERIOD_MS * (`RFHSP_CLK_HZ / 1000),
  parameter FLASH_IDLE   = `RFHSP_FLASH_MS_IDLE * (`RFHSP_CLK_HZ / 1000),
  parameter FLASH_ACT    = `RFHSP_FLASH_MS_ACT * (`RFHSP_CLK_HZ / 1000)
) (
  input  wire        i_core_clk,
  input  wire        i_nrst,
  input  wire        i_ce,
  // pins
  input  wire        i_power_down_n,
  input  wire        i_cmd_data_in,
  input  wire        i_byte_class,
  input  wire        i_factory_default_trigger,
  output reg         o_cmd_data_out,
  output wire        o_cts_n,
  output reg         o_response_marker_n,
  output wire        o_tx_buffer_drained,
  output reg         o_exception_flag_out,
  output wire        o_receive_amp_enable,
  output wire        o_transmit_amp_enable,
  output reg         o_activity_indicator,
  // register port
  input  wire [3:0]  i_addr,
  input  wire [7:0]  i_wdata,
  input  wire        i_wr,
  input  wire        i_rd,
  output reg  [7:0]  o_rdata,
  // engine side
  input  wire        i_ack,
  input  wire [7:0]  i_exc_event,
  output wire        o_defaults_restore,
  output wire        o_irq
);

  ////////////////////////////////////////////////////////////////////////
  // input synchronisers and the run enable
  reg  [1:0] pd_sync_ff;
  reg  [1:0] rx_sync_ff;
  reg  [1:0] cls_sync_ff;
  reg  [1:0] pb_sync_ff;
  wire       run = i_ce & pd_sync_ff[1];

  always @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      pd_sync_ff  <= 2'h0;
      rx_sync_ff  <= 2'h3;
      cls_sync_ff <= 2'h0;
      pb_sync_ff  <= 2'h0;
    end else if (i_ce) begin
      pd_sync_ff  <= {pd_sync_ff[0], i_power_down_n};
      rx_sync_ff  <= {rx_sync_ff[0], i_cmd_data_in};
      cls_sync_ff <= {cls_sync_ff[0], i_byte_class};
      pb_sync_ff  <= {pb_sync_ff[0], i_factory_default_trigger};
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // registers
  reg  [7:0]       ctrl_ff;
  reg  [7:0]       exc_ff;
  reg  [7:0]       exc_mask_ff;
  reg  [3:0]       irq_stat_ff;
  reg  [3:0]       irq_en_ff;
  reg  [7:0]       rx_byte_ff;
  reg              rx_valid_ff;
  reg              rx_cmd_ff;
  reg  [1:0]       rf_state_ff;
  reg  [DIV_W-1:0] div_ff;
  reg              defaults_ff;
  reg              wait_ack_ff;
  // reset divider held at 32 bits, cut to DIV_W where it is loaded
  localparam [31:0] DIV_RST = `RFHSP_BAUD_DIV;

  wire [7:0]       rx_data;
  wire             rx_valid;
  wire             rx_ferr;
  wire             tx_busy;
  reg              tx_load;
  reg  [7:0]       tx_byte;
  reg              tx_is_resp;

  function hit;
    input [3:0] a;
    input [3:0] off;
    begin
      hit = (a == off);
    end
  endfunction

  wire rd_exc   = i_rd & hit(i_addr, `RFHSP_OFF_EXC);
  wire rd_rx    = i_rd & (hit(i_addr, `RFHSP_OFF_CMD_DATA) | hit(i_addr, `RFHSP_OFF_PAY_DATA));
  wire exc_new  = |(i_exc_event & exc_mask_ff);
  wire defaults_pulse;
  wire [3:0] irq_ev = {rx_ferr, defaults_pulse, exc_new, rx_valid};

  always @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      ctrl_ff              <= `RFHSP_CTRL_RESET;
      exc_ff               <= 8'h00;
      exc_mask_ff          <= `RFHSP_EXC_MASK_RESET;
      irq_stat_ff          <= 4'h0;
      irq_en_ff            <= 4'h0;
      rx_byte_ff           <= 8'h00;
      rx_valid_ff          <= 1'b0;
      rx_cmd_ff            <= 1'b0;
      rf_state_ff          <= `RFHSP_RF_IDLE;
      div_ff               <= DIV_RST[DIV_W-1:0];
      o_exception_flag_out <= 1'b0;
      wait_ack_ff          <= 1'b0;
      o_rdata              <= 8'h00;
    end else if (run) begin
      if (i_wr && hit(i_addr, `RFHSP_OFF_CTRL))     ctrl_ff     <= i_wdata;
      if (i_wr && hit(i_addr, `RFHSP_OFF_EXC_MASK)) exc_mask_ff <= i_wdata;
      if (i_wr && hit(i_addr, `RFHSP_OFF_IRQ_EN))   irq_en_ff   <= i_wdata[3:0];
      if (i_wr && hit(i_addr, `RFHSP_OFF_RF_STATE)) rf_state_ff <= i_wdata[1:0];
      if (i_wr && hit(i_addr, `RFHSP_OFF_BAUD))     div_ff      <= {{(DIV_W-8){1'b0}}, i_wdata};
      // set wins over clear
      irq_stat_ff <= (irq_stat_ff & ~((i_wr && hit(i_addr, `RFHSP_OFF_IRQ_CLR)) ? i_wdata[3:0] : 4'h0))
                     | irq_ev;
      // exception register: read clears, new events still land
      exc_ff <= (rd_exc ? 8'h00 : exc_ff) | (i_exc_event & exc_mask_ff);
      if (exc_new) begin
        o_exception_flag_out <= 1'b1;
      end else if (rd_exc) begin
        o_exception_flag_out <= 1'b0;
      end
      if (rx_valid) begin
        rx_byte_ff  <= rx_data;
        rx_valid_ff <= 1'b1;
        rx_cmd_ff   <= !cls_sync_ff[1];
      end else if (rd_rx) begin
        rx_valid_ff <= 1'b0;
      end
      if (rx_valid && cls_sync_ff[1] && ctrl_ff[`RFHSP_CTRL_ACK_EN]) begin
        wait_ack_ff <= 1'b1;
      end else if (i_ack || exc_new) begin
        wait_ack_ff <= 1'b0;
      end
      o_rdata <= 8'h00;
      if (i_rd) begin
        case (i_addr)
          `RFHSP_OFF_CTRL:     o_rdata <= ctrl_ff;
          `RFHSP_OFF_STATUS:   o_rdata <= {3'h0, rx_cmd_ff, defaults_ff, o_tx_buffer_drained, tx_busy, rx_valid_ff};
          `RFHSP_OFF_EXC:      o_rdata <= exc_ff;
          `RFHSP_OFF_EXC_MASK: o_rdata <= exc_mask_ff;
          `RFHSP_OFF_IRQ_STAT: o_rdata <= {4'h0, irq_stat_ff};
          `RFHSP_OFF_IRQ_EN:   o_rdata <= {4'h0, irq_en_ff};
          `RFHSP_OFF_CMD_DATA: o_rdata <= rx_byte_ff;
          `RFHSP_OFF_PAY_DATA: o_rdata <= rx_byte_ff;
          `RFHSP_OFF_RF_STATE: o_rdata <= {6'h00, rf_state_ff};
          `RFHSP_OFF_BAUD:     o_rdata <= div_ff[7:0];
          default:             o_rdata <= 8'h00;
        endcase
      end
    end
  end

  assign o_irq = |(irq_stat_ff & irq_en_ff);
  // busy until software took the last byte; no second buffer
  assign o_cts_n = rx_valid_ff | !pd_sync_ff[1];
  assign o_tx_buffer_drained = !rx_valid_ff & !wait_ack_ff;
  assign o_receive_amp_enable  = run & (rf_state_ff == `RFHSP_RF_RX);
  assign o_transmit_amp_enable = run & (rf_state_ff == `RFHSP_RF_TX);

  ////////////////////////////////////////////////////////////////////////
  // receiver
  rfhsp_uart_rx #(.DIV_W(DIV_W)) u_rx (
    .i_core_clk  (i_core_clk),
    .i_nrst      (i_nrst),
    .i_ce        (run),
    .i_div       (div_ff),
    .i_rx        (rx_sync_ff[1]),
    .o_data      (rx_data),
    .o_valid     (rx_valid),
    .o_frame_err (rx_ferr)
  );

  ////////////////////////////////////////////////////////////////////////
  // transmitter: one line for payload and responses
  reg [9:0]       tsh_ff;
  reg [3:0]       tbits_ff;
  reg [DIV_W-1:0] tcnt_ff;
  assign tx_busy = (tbits_ff != 4'h0);

  always @* begin
    tx_load    = run & !tx_busy & i_wr &
                 (hit(i_addr, `RFHSP_OFF_CMD_DATA) | hit(i_addr, `RFHSP_OFF_PAY_DATA));
    tx_byte    = i_wdata;
    tx_is_resp = hit(i_addr, `RFHSP_OFF_CMD_DATA);
  end

  always @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      tsh_ff              <= 10'h3ff;
      tbits_ff            <= 4'h0;
      tcnt_ff             <= {DIV_W{1'b0}};
      o_cmd_data_out      <= 1'b1;
      o_response_marker_n <= 1'b1;
    end else if (run) begin
      if (tx_load) begin
        tsh_ff              <= {1'b1, tx_byte, 1'b0};
        tbits_ff            <= 4'ha;
        tcnt_ff             <= div_ff;
        o_cmd_data_out      <= 1'b0;
        o_response_marker_n <= !tx_is_resp;
      end else if (tx_busy) begin
        if (tcnt_ff != {DIV_W{1'b0}}) begin
          tcnt_ff <= tcnt_ff - 1'b1;
        end else begin
          tcnt_ff        <= div_ff;
          tsh_ff         <= {1'b1, tsh_ff[9:1]};
          tbits_ff       <= tbits_ff - 1'b1;
          o_cmd_data_out <= (tbits_ff == 4'h1) ? 1'b1 : tsh_ff[1];
          if (tbits_ff == 4'h1) begin
            o_response_marker_n <= 1'b1;
          end
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // factory-default sequence detector
  reg        pb_prev_ff;
  reg [2:0]  pcnt_ff;
  reg [31:0] hcnt_ff;
  reg [31:0] gap_ff;
  reg        restore_ff;
  assign defaults_pulse     = restore_ff;
  assign o_defaults_restore = restore_ff;

  always @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      pb_prev_ff  <= 1'b0;
      pcnt_ff     <= 3'h0;
      hcnt_ff     <= 32'h0;
      gap_ff      <= 32'h0;
      restore_ff  <= 1'b0;
      defaults_ff <= 1'b0;
    end else if (run) begin
      pb_prev_ff <= pb_sync_ff[1];
      restore_ff <= 1'b0;
      if (pb_sync_ff[1]) begin
        gap_ff <= 32'h0;
        if (hcnt_ff != LONG_HIGH) hcnt_ff <= hcnt_ff + 32'h1;
        if (hcnt_ff == LONG_HIGH - 1 && pcnt_ff == `RFHSP_PULSE_COUNT) begin
          restore_ff  <= 1'b1;
          defaults_ff <= 1'b1;
          pcnt_ff     <= 3'h0;
        end
      end else begin
        hcnt_ff <= 32'h0;
        if (pb_prev_ff && hcnt_ff != LONG_HIGH && pcnt_ff != `RFHSP_PULSE_COUNT) begin
          pcnt_ff <= pcnt_ff + 3'h1;
        end
        if (gap_ff == PULSE_GAP) begin
          pcnt_ff <= 3'h0; // sequence abandoned
        end else begin
          gap_ff <= gap_ff + 32'h1;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // activity indicator: flash length shows idle vs rf busy
  reg [31:0] fcnt_ff;
  wire [31:0] flash_len = (rf_state_ff == `RFHSP_RF_IDLE) ? FLASH_IDLE : FLASH_ACT;

  always @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      fcnt_ff              <= 32'h0;
      o_activity_indicator <= 1'b0;
    end else if (run) begin
      fcnt_ff              <= (fcnt_ff >= FLASH_PERIOD - 1) ? 32'h0 : fcnt_ff + 32'h1;
      o_activity_indicator <= (fcnt_ff < flash_len);
    end
  end

endmodule // rfhsp_top

// ===== verif/rfhsp_top_chk.sv
/*
  port assertions for the radio host serial port.
  assumes a 100 mhz core clock and the bind at the foot of this file.
*/
module rfhsp_top_chk (
  input wire       i_core_clk,
  input wire       i_nrst,
  input wire       i_ce,
  input wire       i_power_down_n,
  input wire [3:0] i_addr,
  input wire [7:0] i_wdata,
  input wire       i_wr,
  input wire       i_rd,
  input wire [7:0] i_exc_event,
  input wire       o_cmd_data_out,
  input wire       o_cts_n,
  input wire       o_response_marker_n,
  input wire       o_tx_buffer_drained,
  input wire       o_exception_flag_out,
  input wire       o_receive_amp_enable,
  input wire       o_transmit_amp_enable,
  input wire       o_defaults_restore
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_nrst);
  // power-down pin passes a two-stage sync, so three samples are needed
  sequence up_s;
    (i_power_down_n && i_ce)[*3];
  endsequence
  ////////////////////////////////////////////////////////////
  chk_flag_cause:
    assert property ($rose(o_exception_flag_out) |-> $past(i_exc_event) != 8'h00) else $error("flag rose without event");
  chk_flag_clear:
    assert property (up_s ##0 (i_rd && i_addr == 4'h2 && i_exc_event == 8'h00) |=> !o_exception_flag_out)
      else $error("flag stayed after read");
  chk_pd_quiet:
    assert property (!i_power_down_n [*3] |-> o_cts_n && !o_receive_amp_enable && !o_transmit_amp_enable)
      else $error("active in power down");
  chk_amps_apart:
    assert property (!(o_receive_amp_enable && o_transmit_amp_enable)) else $error("both amps on");
  chk_tx_amp_write:
    assert property (up_s ##0 (i_wr && i_addr == 4'h9 && i_wdata == 8'h02) |=> o_transmit_amp_enable)
      else $error("tx amp not on");
  chk_rx_amp_write:
    assert property (up_s ##0 (i_wr && i_addr == 4'h9 && i_wdata == 8'h01) |=> o_receive_amp_enable)
      else $error("rx amp not on");
  chk_marker_start:
    assert property ($fell(o_response_marker_n) |-> !o_cmd_data_out) else $error("marker without start bit");
  chk_cts_read:
    assert property (up_s ##0 (i_rd && (i_addr == 4'h7 || i_addr == 4'h8)) |=> !o_cts_n)
      else $error("cts stayed busy");
  chk_drained_cts:
    assert property (up_s ##0 o_tx_buffer_drained |-> !o_cts_n) else $error("drained with byte held");
  chk_restore_once:
    assert property (o_defaults_restore |=> !o_defaults_restore) else $error("restore longer than one cycle");
  cov_flag: cover property ($rose(o_exception_flag_out));
  cov_marker: cover property ($fell(o_response_marker_n));
  cov_restore: cover property (o_defaults_restore);
endmodule // rfhsp_top_chk

bind rfhsp_top rfhsp_top_chk u_chk (.i_core_clk, .i_nrst, .i_ce, .i_power_down_n, .i_addr, .i_wdata, .i_wr,
  .i_rd, .i_exc_event, .o_cmd_data_out, .o_cts_n, .o_response_marker_n, .o_tx_buffer_drained,
  .o_exception_flag_out, .o_receive_amp_enable, .o_transmit_amp_enable, .o_defaults_restore);

// ===== verif/rfhsp_host.sv
/*
  host side model: 8n1 sender honouring clear-to-send, and a receiver.
  assumes BIT core cycles per serial bit and a caller just after an edge.
*/
module rfhsp_host #(
  parameter int BIT = 5
) (
  input  wire  i_core_clk,
  input  wire  i_cts_n,
  input  wire  i_serial,
  output logic o_serial,
  output logic o_class
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    o_serial = 1'b1;
    o_class  = 1'b1;
  end
  ////////////////////////////////////////////////////////////
  task automatic send(input logic [7:0] d, input logic cls, output logic ok);
    logic [9:0] fr;
    int         n;
    fr = {1'b1, d, 1'b0};
    n = 0;
    while (i_cts_n !== 1'b0 && n < 500) begin
      @(posedge i_core_clk);
      n++;
    end
    ok = (n < 500);
    o_class <= cls;
    for (int i = 0; i < 10; i++) begin
      o_serial <= fr[i];
      repeat (BIT) @(posedge i_core_clk);
    end
  endtask
  task automatic recv(output logic [7:0] d, output logic ok);
    int n;
    n = 0;
    while (i_serial !== 1'b0 && n < 400) begin
      @(posedge i_core_clk);
      n++;
    end
    ok = (n < 400);
    repeat (BIT / 2) @(posedge i_core_clk);
    ok = ok && (i_serial === 1'b0);
    for (int i = 0; i < 8; i++) begin
      repeat (BIT) @(posedge i_core_clk);
      d[i] = i_serial;
    end
    repeat (BIT) @(posedge i_core_clk);
    ok = ok && (i_serial === 1'b1);
  endtask
endmodule // rfhsp_host

// ===== verif/rfhsp_top_test.sv
/*
  self-checking bench for the radio host serial port.
  assumes short timing parameters and a baud divider of 4 (5 cycles a bit).
*/
module rfhsp_top_test;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int LH = 50;
  localparam int FI = 10;
  localparam int FA = 40;
  logic       i_core_clk, i_nrst, i_ce, i_power_down_n, i_cmd_data_in, i_byte_class;
  logic       i_factory_default_trigger, i_wr, i_rd, i_ack;
  logic [3:0] i_addr;
  logic [7:0] i_wdata, i_exc_event, o_rdata, s;
  logic       o_cmd_data_out, o_cts_n, o_response_marker_n, o_tx_buffer_drained, o_exception_flag_out;
  logic       o_receive_amp_enable, o_transmit_amp_enable, o_activity_indicator, o_defaults_restore, o_irq, ok;
  int         num_errors, compares, rcnt;
  rfhsp_top #(.LONG_HIGH(LH), .PULSE_GAP(50), .FLASH_PERIOD(100), .FLASH_IDLE(FI), .FLASH_ACT(FA)) DUT (
    .i_core_clk, .i_nrst, .i_ce, .i_power_down_n, .i_cmd_data_in, .i_byte_class, .i_factory_default_trigger,
    .o_cmd_data_out, .o_cts_n, .o_response_marker_n, .o_tx_buffer_drained, .o_exception_flag_out,
    .o_receive_amp_enable, .o_transmit_amp_enable, .o_activity_indicator, .i_addr, .i_wdata, .i_wr, .i_rd,
    .o_rdata, .i_ack, .i_exc_event, .o_defaults_restore, .o_irq);
  rfhsp_host #(.BIT(5)) host (.i_core_clk, .i_cts_n(o_cts_n), .i_serial(o_cmd_data_out),
    .o_serial(i_cmd_data_in), .o_class(i_byte_class));
  initial begin
    i_core_clk = 1'b0;
    forever #5 i_core_clk = ~i_core_clk;
  end
  always @(posedge i_core_clk) if (o_defaults_restore === 1'b1) rcnt++;
  ////////////////////////////////////////////////////////////
  task automatic close_out;
    $display("compares %0d num_errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic okay(input logic k);
    if (k !== 1'b1) begin
      num_errors++;
      close_out();
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge i_core_clk);
    #1;
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge i_core_clk);
    i_addr  <= a;
    i_wdata <= d;
    i_wr    <= 1'b1;
    @(posedge i_core_clk);
    i_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge i_core_clk);
    i_addr <= a;
    i_rd   <= 1'b1;
    @(posedge i_core_clk);
    i_rd <= 1'b0;
    #1 d = o_rdata;
  endtask
  task automatic exc(input logic [7:0] v);
    @(posedge i_core_clk);
    i_exc_event <= v;
    @(posedge i_core_clk);
    i_exc_event <= 8'h00;
    #1;
  endtask
  ////////////////////////////////////////////////////////////
  task automatic t_tx(input logic [3:0] a, input logic [7:0] d, input logic mk);
    logic [7:0] b;
    fork
      host.recv(b, ok);
      begin
        wr(a, d);
        #1 chk("marker", o_response_marker_n, mk);
      end
    join
    okay(ok);
    chk("tx byte", b, d);
    cyc(4);
    chk("marker idle", o_response_marker_n, 1);
  endtask
  task automatic t_rx(input logic cls, input logic [7:0] d);
    host.send(d, cls, ok);
    okay(ok);
    cyc(3);
    chk("cts busy", o_cts_n, 1);
    chk("not drained", o_tx_buffer_drained, 0);
    rd(4'h1, s);
    chk("class", s[4], !cls);
    rd(cls ? 4'h8 : 4'h7, s);
    chk("rx byte", s, d);
    cyc(1);
    chk("cts ready", o_cts_n, 0);
    chk("drained", o_tx_buffer_drained, 1);
  endtask
  task automatic t_exc;
    wr(4'h3, 8'h01);
    exc(8'h02);
    chk("masked flag", o_exception_flag_out, 0);
    exc(8'h01);
    chk("flag", o_exception_flag_out, 1);
    wr(4'h6, 8'h02);
    #1 chk("irq on", o_irq, 1);
    wr(4'h6, 8'h00);
    #1 chk("irq masked", o_irq, 0);
    wr(4'h6, 8'h02);
    rd(4'h2, s);
    chk("exc reg", s[0], 1);
    cyc(1);
    chk("flag read", o_exception_flag_out, 0);
    wr(4'h5, 8'h02);
    cyc(1);
    chk("irq cleared", o_irq, 0);
    rd(4'h4, s);
    chk("irq stat", s[1], 0);
    wr(4'h6, 8'h00);
    wr(4'h3, 8'hff);
  endtask
  task automatic t_ack(input logic retry);
    wr(4'h0, 8'h01);
    host.send(8'h5a, 1'b1, ok);
    okay(ok);
    cyc(3);
    rd(4'h8, s);
    cyc(1);
    chk("wait ack", o_tx_buffer_drained, 0);
    if (retry) begin
      exc(8'h01);
      rd(4'h2, s);
    end else begin
      @(posedge i_core_clk);
      i_ack <= 1'b1;
      @(posedge i_core_clk);
      i_ack <= 1'b0;
    end
    cyc(1);
    chk("acked", o_tx_buffer_drained, 1);
    wr(4'h0, 8'h00);
  endtask
  task automatic t_amp_pd;
    wr(4'h9, 8'h01);
    #1 chk("rx amp", {o_receive_amp_enable, o_transmit_amp_enable}, 2'b10);
    wr(4'h9, 8'h02);
    #1 chk("tx amp", {o_receive_amp_enable, o_transmit_amp_enable}, 2'b01);
    i_power_down_n <= 1'b0;
    cyc(4);
    chk("pd", {o_cts_n, o_receive_amp_enable, o_transmit_amp_enable}, 3'b100);
    i_power_down_n <= 1'b1;
    cyc(4);
    chk("wake", {o_cts_n, o_receive_amp_enable, o_transmit_amp_enable}, 3'b001);
  endtask
  task automatic t_flash(input logic [7:0] st, input int exp);
    int n;
    n = 0;
    wr(4'h9, st);
    cyc(100);
    repeat (200) begin
      @(posedge i_core_clk);
      n += (o_activity_indicator === 1'b1);
    end
    chk("flash", n[7:0], exp[7:0]);
  endtask
  task automatic t_fd(input int pulses, input int exp);
    i_factory_default_trigger <= 1'b0;
    cyc(60);
    rcnt = 0;
    repeat (pulses) begin
      i_factory_default_trigger <= 1'b1;
      cyc(5);
      i_factory_default_trigger <= 1'b0;
      cyc(5);
    end
    i_factory_default_trigger <= 1'b1;
    cyc(LH + 20);
    i_factory_default_trigger <= 1'b0;
    chk("restores", rcnt[7:0], exp[7:0]);
  endtask
  ////////////////////////////////////////////////////////////
  initial begin
    i_nrst = 1'b0;
    i_ce = 1'b1;
    i_power_down_n = 1'b1;
    i_factory_default_trigger = 1'b0;
    i_addr = 4'h0;
    i_wdata = 8'h00;
    i_wr = 1'b0;
    i_rd = 1'b0;
    i_ack = 1'b0;
    i_exc_event = 8'h00;
    num_errors = 0;
    compares = 0;
    rcnt = 0;
    cyc(10);
    i_nrst <= 1'b1;
    cyc(3);
    chk("reset pins", {o_cmd_data_out, o_cts_n, o_response_marker_n, o_tx_buffer_drained,
      o_exception_flag_out, o_receive_amp_enable, o_transmit_amp_enable, o_irq}, 8'hb0);
    rd(4'h3, s);
    chk("mask reset", s, 8'hff);
    rd(4'hf, s);
    chk("unmapped", s, 8'h00);
    wr(4'ha, 8'h04);
    t_tx(4'h7, 8'ha5, 1'b0);
    t_tx(4'h8, 8'h3c, 1'b1);
    t_rx(1'b0, 8'h81);
    t_rx(1'b1, 8'h7e);
    t_exc();
    t_ack(1'b0);
    t_ack(1'b1);
    t_amp_pd();
    t_flash(8'h00, 2 * FI);
    t_flash(8'h01, 2 * FA);
    t_fd(3, 0);
    t_fd(4, 1);
    close_out();
  end
endmodule // rfhsp_top_test
